/* hdl/pls_defs.svh */
/*
 Constants for the converter sequencing block: thresholds, timing counts and
 PFC timing. Assumes a 40 MHz system clock and digitised sense codes.
*/
`ifndef PLS_DEFS_SVH
`define PLS_DEFS_SVH
`define PLS_CLK_HZ 40000000
// Sense codes are 12 bit, scaled 1 code per volt (peak for line, dc bulk)
`define PLS_BROWNOUT_PK 12'h063
`define PLS_UV_RISE_PK 12'h071
`define PLS_HALT_PK 12'h1c4
`define PLS_XCAP_SAFE 12'h02a
`define PLS_BULK_SENSE_INPUT_REG 12'h181
// Times in their own units
`define PLS_LOSS_MS 32
`define PLS_STOP_MS 100
`define PLS_DITHER_HZ 333
`define PLS_BURST_MS 300
`define PLS_LLC_SS_MS 100
`define PLS_PFC_SS_MS 50
`define PLS_DITHER_STEP_KHZ 2
`define PLS_PFC_BASE_KHZ 100
`define PLS_DUTY_MAX_PCT 92
// Cycle counts
`define PLS_LOSS_CYC (`PLS_CLK_HZ / 1000 * `PLS_LOSS_MS)
`define PLS_STOP_CYC (`PLS_CLK_HZ / 1000 * `PLS_STOP_MS)
`define PLS_DITHER_CYC (`PLS_CLK_HZ / `PLS_DITHER_HZ)
`define PLS_BURST_CYC (`PLS_CLK_HZ / 1000 * `PLS_BURST_MS)
`define PLS_LLC_SS_CYC (`PLS_CLK_HZ / 1000 * `PLS_LLC_SS_MS)
`define PLS_PFC_SS_CYC (`PLS_CLK_HZ / 1000 * `PLS_PFC_SS_MS)
// Half-cycle with no zero crossing longer than this means line gone (20 ms)
`define PLS_ZC_GONE_CYC 800000
// LLC periods in clocks: 350 kHz max freq, 70 kHz min freq
`define PLS_LLC_PMIN 16'h0072
`define PLS_LLC_PMAX 16'h023b
`endif

/* hdl/pls_pkg.sv */
/*
 Types for the converter sequencing block. Needs pls_defs.svh constants only
 inside the design module.
*/
package pls_pkg;
   typedef struct packed {
      logic [11:0] lineMag;
      logic [11:0] bulk;
      logic [11:0] xcap;
   } pls_sense_t;
   typedef enum logic [2:0] {
      ST_CHECK, ST_FAULT, ST_SOFT, ST_RUN, ST_LOSS, ST_HALT
   } pls_state_t;
endpackage

/* hdl/pls_sequencer.sv */
/*
 Sequencing, brownout, dither, X-cap discharge, soft start and PFC PWM
 for a combined PFC and LLC controller. Assumes the sense inputs are already
 digitised codes from converters on clk_sys; the zero-cross, burst and
 power-on inputs come from pins and are synchronised here.
*/
// How it works
// - Latch a fault and never start if bulk is below the line peak.
// - While PFC runs, a half-cycle is valid only if its peak beats 70 V.
// - Loss flag rises after more than 32 ms with no valid half-cycle.
// - Both stages stop 100 ms after the loss flag rises.
// - One missing half-cycle is far short of 32 ms, so no action.
// - PFC frequency steps among three values at 333 Hz.
// - The three frequencies are 2 kHz apart.
// - No discharge action when zero crossings stop while PFC switches.
// - In burst mode wait 300 ms, then decide on the sampled X-cap.
// - Discharge decision lands well inside 1 s of line removal.
// - LLC soft start sweeps period from minimum to maximum in 100 ms.
// - Sweep ends once feedback asks for a higher frequency.
// - The first LLC pulse is on gate A and half normal width.
// - Line current demand clipped to the -225 mV sense equivalent.
// - Demand is voltage-loop output times rectified line voltage.
// - PFC duty can be 0 percent, gate low for the whole period.
// - PFC gate supports at least 92 percent duty; the clip rounds down, so the 392-clock period reaches only 360 clocks on.
// - PFC may start only at or above the 80 V rising threshold.
// - Both stages halt at or above the 320 V threshold.
`timescale 1ns/1ps
`include "pls_defs.svh"
module pls_sequencer
   import pls_pkg::*;
#(
   parameter int LOSS_CYC = `PLS_LOSS_CYC,
   parameter int STOP_CYC = `PLS_STOP_CYC,
   parameter int BURST_CYC = `PLS_BURST_CYC,
   parameter int LLC_SS_CYC = `PLS_LLC_SS_CYC,
   parameter int PFC_SS_CYC = `PLS_PFC_SS_CYC,
   parameter int ZC_GONE_CYC = `PLS_ZC_GONE_CYC,
   parameter int DITHER_CYC = `PLS_DITHER_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Digitised sense codes
   input wire pls_sense_t sense,
   input wire logic [11:0] voltLoopOut,
   // Pin level inputs
   input wire logic zeroCross,
   input wire logic burstMode,
   input wire logic bias_select_power_on,
   input wire logic [15:0] llc_feedback,
   // Outputs to the power stage
   output logic ac_loss_flag,
   output logic startup_fet_gate,
   output logic boost_gate_drive,
   output logic llc_gate_a,
   output logic llc_gate_b,
   output logic [23:0] avg_current_demand,
   output logic [11:0] pfcCurrentLimit
);
   ////////////////////////////////////////////////////////////////////////
   // Three-stage synchronisers; a change counts when stages 2 and 3 agree
   logic [2:0] zcSync_r, burstSync_r, psOnSync_r;
   logic zc_r, burst_r, psOn_r, zcPrev_r;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         zcSync_r <= 3'h0;
         burstSync_r <= 3'h0;
         psOnSync_r <= 3'h0;
      end else begin
         zcSync_r <= {zcSync_r[1:0], zeroCross};
         burstSync_r <= {burstSync_r[1:0], burstMode};
         psOnSync_r <= {psOnSync_r[1:0], bias_select_power_on};
      end
   end
   // Filtered levels follow only when the later two stages agree
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         zc_r <= 1'b0;
         burst_r <= 1'b0;
         psOn_r <= 1'b0;
         zcPrev_r <= 1'b0;
      end else begin
         if (zcSync_r[2] == zcSync_r[1]) zc_r <= zcSync_r[2];
         if (burstSync_r[2] == burstSync_r[1]) burst_r <= burstSync_r[2];
         if (psOnSync_r[2] == psOnSync_r[1]) psOn_r <= psOnSync_r[2];
         zcPrev_r <= zc_r;
      end
   end
   logic zcEdge;
   assign zcEdge = zc_r != zcPrev_r;
   ////////////////////////////////////////////////////////////////////////
   // Half-cycle peak tracking and validity
   pls_state_t state_r;
   logic pfcRun;
   logic [11:0] peak_r;
   logic [31:0] noValid_r, stopCnt_r, zcGap_r;
   assign pfcRun = (state_r == ST_SOFT) || (state_r == ST_RUN) ||
                   (state_r == ST_LOSS);
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         peak_r <= 12'h000;
      end else if (zcEdge) begin
         peak_r <= sense.lineMag;
      end else if (sense.lineMag > peak_r) begin
         peak_r <= sense.lineMag;
      end
   end
   logic validHalf;
   assign validHalf = zcEdge && pfcRun &&
                      (peak_r > `PLS_BROWNOUT_PK);
   // No-valid timer; a single missed half-cycle is ~10 ms, under 32 ms
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !pfcRun || validHalf) begin
         noValid_r <= 32'h0;
      end else if (noValid_r <= LOSS_CYC) begin
         noValid_r <= noValid_r + 32'h1;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ac_loss_flag <= 1'b0;
      end else if (noValid_r > LOSS_CYC) begin
         ac_loss_flag <= 1'b1;
      end else if (validHalf) begin
         ac_loss_flag <= 1'b0;
      end
   end
   // Stop delay after the loss flag
   always_ff @(posedge clk_sys) begin
      if (!reset_n || state_r != ST_LOSS) begin
         stopCnt_r <= 32'h0;
      end else begin
         stopCnt_r <= stopCnt_r + 32'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Main sequencer; a halt, a loss, or a power-off in soft start or run stops both stages; a sense fault only blocks the start
   logic halt, llcSoftDone;
   assign halt = sense.lineMag >= `PLS_HALT_PK;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_r <= ST_CHECK;
      end else begin
         unique case (state_r)
            ST_CHECK: begin
               if (sense.bulk < sense.lineMag) state_r <= ST_FAULT;
               else if (psOn_r && !halt &&
                        sense.lineMag >= `PLS_UV_RISE_PK)
                  state_r <= ST_SOFT;
            end
            ST_FAULT: state_r <= ST_FAULT; // Latched until reset
            ST_SOFT, ST_RUN: begin
               if (halt || !psOn_r) state_r <= ST_HALT;
               else if (ac_loss_flag) state_r <= ST_LOSS;
               else if (state_r == ST_SOFT && llcSoftDone) state_r <= ST_RUN;
            end
            ST_LOSS: begin
               if (halt || stopCnt_r >= STOP_CYC - 1)
                  state_r <= ST_HALT;
            end
            ST_HALT: begin
               if (!halt && sense.lineMag < `PLS_UV_RISE_PK && !psOn_r)
                  state_r <= ST_CHECK;
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // X-cap discharge: only when line goes away with PFC idle
   logic [31:0] latency_r;
   logic zcGone, pending_r;
   assign zcGone = zcGap_r >= ZC_GONE_CYC;
   always_ff @(posedge clk_sys) begin
      if (!reset_n || zcEdge) begin
         zcGap_r <= 32'h0;
      end else if (!zcGone) begin
         zcGap_r <= zcGap_r + 32'h1;
      end
   end
   // Burst latency is counted, then the decision samples the cap then
   always_ff @(posedge clk_sys) begin
      if (!reset_n || zcEdge) begin
         pending_r <= 1'b0;
         latency_r <= 32'h0;
      end else if (zcGone && !pfcRun && !startup_fet_gate) begin
         pending_r <= 1'b1;
         if (pending_r && burst_r && latency_r < BURST_CYC)
            latency_r <= latency_r + 32'h1;
      end else begin
         pending_r <= 1'b0;
         latency_r <= 32'h0;
      end
   end
   // Gap 20 ms plus latency 300 ms keeps the decision inside 1 s
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         startup_fet_gate <= 1'b0;
      end else if (startup_fet_gate) begin
         if (sense.xcap < `PLS_XCAP_SAFE || zcEdge)
            startup_fet_gate <= 1'b0;
      end else if (pending_r && (!burst_r || latency_r >= BURST_CYC) &&
                   sense.xcap > `PLS_XCAP_SAFE) begin
         startup_fet_gate <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Dither: three periods stepped at 333 Hz, 2 kHz apart
   localparam logic [8:0] PER0 = 9'(`PLS_CLK_HZ /
                           ((`PLS_PFC_BASE_KHZ - `PLS_DITHER_STEP_KHZ) * 1000));
   localparam logic [8:0] PER1 = 9'(`PLS_CLK_HZ / (`PLS_PFC_BASE_KHZ * 1000));
   localparam logic [8:0] PER2 = 9'(`PLS_CLK_HZ /
                           ((`PLS_PFC_BASE_KHZ + `PLS_DITHER_STEP_KHZ) * 1000));
   logic [1:0] ditherSel_r;
   logic [31:0] ditherCnt_r;
   logic [8:0] pfcPeriod;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ditherCnt_r <= 32'h0;
         ditherSel_r <= 2'h0;
      end else if (ditherCnt_r >= DITHER_CYC - 1) begin
         ditherCnt_r <= 32'h0;
         ditherSel_r <= (ditherSel_r == 2'h2) ? 2'h0 : ditherSel_r + 2'h1;
      end else begin
         ditherCnt_r <= ditherCnt_r + 32'h1;
      end
   end
   always_comb begin
      unique case (ditherSel_r)
         2'h0: pfcPeriod = PER0;
         2'h1: pfcPeriod = PER1;
         default: pfcPeriod = PER2;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   // PFC soft start limit and average current demand
   logic [11:0] dv;
   logic [23:0] demand;
   logic [23:0] limitWide;
   assign dv = (`PLS_BULK_SENSE_INPUT_REG > sense.bulk) ?
               12'(`PLS_BULK_SENSE_INPUT_REG - sense.bulk) : 12'h000;
   // Limit set to the bulk step still needed while in check; full limit once in run
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pfcCurrentLimit <= 12'h000;
      end else if (state_r == ST_CHECK) begin
         pfcCurrentLimit <= dv;
      end else if (state_r == ST_RUN) begin
         pfcCurrentLimit <= 12'hfff;
      end
   end
   assign demand = 24'(voltLoopOut) * 24'(sense.lineMag);
   assign limitWide = {pfcCurrentLimit, 12'h000};
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !pfcRun) begin
         avg_current_demand <= 24'h0;
      end else if (demand > limitWide) begin
         avg_current_demand <= limitWide;
      end else begin
         avg_current_demand <= demand;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // PFC PWM: duty from demand top bits, clipped at 92 percent
   logic [8:0] pwmCnt_r;
   logic [8:0] onTime, maxOn;
   logic [17:0] onProd;
   assign maxOn = 9'((18'(pfcPeriod) * `PLS_DUTY_MAX_PCT) / 100);
   assign onProd = 18'(pfcPeriod) * 18'(avg_current_demand[23:15]);
   assign onTime = (onProd[17:9] > maxOn) ? maxOn : onProd[17:9];
   always_ff @(posedge clk_sys) begin
      if (!reset_n || pwmCnt_r >= pfcPeriod - 9'h1) begin
         pwmCnt_r <= 9'h0;
      end else begin
         pwmCnt_r <= pwmCnt_r + 9'h1;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !pfcRun) begin
         boost_gate_drive <= 1'b0;
      end else begin
         boost_gate_drive <= pwmCnt_r < onTime;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // LLC soft start sweep and gate generation
   localparam logic [31:0] SS_STEP_CYC =
      32'(LLC_SS_CYC / (`PLS_LLC_PMAX - `PLS_LLC_PMIN));
   logic [15:0] llcPeriod_r, llcCnt_r, llcPer;
   logic [31:0] ssCnt_r;
   logic sweep_r, first_r, phase_r;
   assign llcSoftDone = !sweep_r;
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !pfcRun) begin
         llcPeriod_r <= `PLS_LLC_PMIN;
         ssCnt_r <= 32'h0;
         sweep_r <= 1'b1;
      end else if (sweep_r) begin
         if (llc_feedback < llcPeriod_r) begin
            sweep_r <= 1'b0;
         end else if (ssCnt_r >= SS_STEP_CYC - 1) begin
            ssCnt_r <= 32'h0;
            if (llcPeriod_r >= `PLS_LLC_PMAX) sweep_r <= 1'b0;
            else llcPeriod_r <= llcPeriod_r + 16'h1;
         end else begin
            ssCnt_r <= ssCnt_r + 32'h1;
         end
      end
   end
   // Feedback clipped to the legal band so an open loop cannot stall the gates
   logic [15:0] fbClip;
   always_comb begin
      fbClip = llc_feedback;
      if (llc_feedback > `PLS_LLC_PMAX) fbClip = `PLS_LLC_PMAX;
      if (llc_feedback < `PLS_LLC_PMIN) fbClip = `PLS_LLC_PMIN;
   end
   assign llcPer = sweep_r ? llcPeriod_r : fbClip;
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !pfcRun) begin
         llcCnt_r <= 16'h0;
         phase_r <= 1'b0;
         first_r <= 1'b1;
      end else if (llcCnt_r >= ((first_r ? llcPer >> 2 : llcPer >> 1) -
                                16'h1)) begin
         llcCnt_r <= 16'h0;
         phase_r <= !phase_r;
         first_r <= 1'b0;
      end else begin
         llcCnt_r <= llcCnt_r + 16'h1;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !pfcRun) begin
         llc_gate_a <= 1'b0;
         llc_gate_b <= 1'b0;
      end else begin
         llc_gate_a <= !phase_r;
         llc_gate_b <= phase_r;
      end
   end
endmodule

/* bench/pls_seq_chk.sv */
/* Port checker for the sequencing block, bound to its top below.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module pls_seq_chk
   import pls_pkg::*;
#(
   parameter int LOSS_CYC = 320,
   parameter int STOP_CYC = 1000
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Inputs of the block
   input wire pls_sense_t sense,
   input wire logic [11:0] voltLoopOut,
   input wire logic zeroCross,
   // Outputs of the block
   input wire logic ac_loss_flag,
   input wire logic startup_fet_gate,
   input wire logic boost_gate_drive,
   input wire logic llc_gate_a,
   input wire logic llc_gate_b,
   input wire logic [23:0] avg_current_demand,
   input wire logic [11:0] pfcCurrentLimit
);
   logic zcPrev_r;
   int gap_r;
   int lossCnt_r;
   int idle_r;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   /////////////////////////////////////////////////////////////////////////
   // Raw edge runs ahead of the synchroniser, so this gap never undercounts
   always_ff @(posedge clk_sys) begin
      zcPrev_r <= zeroCross;
      if (!reset_n || (zeroCross != zcPrev_r && sense.lineMag > 12'h063)) begin
         gap_r <= 0;
      end else begin
         gap_r <= gap_r + 1;
      end
   end
   // Time the loss flag has stood
   always_ff @(posedge clk_sys) begin
      lossCnt_r <= (reset_n && ac_loss_flag) ? lossCnt_r + 1 : 0;
   end
   // Time since the boost gate was last on
   always_ff @(posedge clk_sys) begin
      idle_r <= (!reset_n || boost_gate_drive) ? 0 : idle_r + 1;
   end
   /////////////////////////////////////////////////////////////////////////
   sequence halt_held;
      (sense.lineMag >= 12'h1c4) [*8];
   endsequence
   sequence demand_steady;
      ($stable(voltLoopOut) && $stable(sense.lineMag)
         && (llc_gate_a || llc_gate_b)
         && pfcCurrentLimit == 12'hfff) [*4];
   endsequence
   a_loss_gap: assert property (
      $rose(ac_loss_flag) |-> gap_r > LOSS_CYC)
      else $error("loss flag rose too early");
   a_stop_loss: assert property (
      lossCnt_r > STOP_CYC + 8 |-> !boost_gate_drive && !llc_gate_a
         && !llc_gate_b) else $error("stages run after loss delay");
   a_halt_stop: assert property (
      halt_held |-> !boost_gate_drive && !llc_gate_a && !llc_gate_b)
      else $error("stages run at halt level");
   a_gate_excl: assert property (
      !(llc_gate_a && llc_gate_b)) else $error("both half-bridge gates on");
   a_dis_xcap: assert property (
      $rose(startup_fet_gate) |-> sense.xcap > 12'h02a)
      else $error("discharge with safe X-cap");
   a_dis_end: assert property (
      startup_fet_gate && sense.xcap < 12'h02a |-> ##[1:8] !startup_fet_gate)
      else $error("discharge did not end");
   a_dis_idle: assert property (
      $rose(startup_fet_gate) |-> idle_r > 150)
      else $error("discharge while boost switches");
   a_dem_prod: assert property (
      demand_steady |-> avg_current_demand
         == 24'(voltLoopOut) * 24'(sense.lineMag))
      else $error("demand is not the product");
endmodule
bind pls_sequencer pls_seq_chk #(
   .LOSS_CYC(LOSS_CYC),
   .STOP_CYC(STOP_CYC)
) u_chk (
   .clk_sys(clk_sys), .reset_n(reset_n), .sense(sense),
   .voltLoopOut(voltLoopOut), .zeroCross(zeroCross),
   .ac_loss_flag(ac_loss_flag), .startup_fet_gate(startup_fet_gate),
   .boost_gate_drive(boost_gate_drive), .llc_gate_a(llc_gate_a),
   .llc_gate_b(llc_gate_b), .avg_current_demand(avg_current_demand),
   .pfcCurrentLimit(pfcCurrentLimit)
);

/* bench/pls_power_stage.sv */
/* Power stage model: line crossings, bulk charging and sense codes.
   Assumes the bench sets line level and X-cap voltage directly. */
`timescale 1ns/1ps
module pls_power_stage
   import pls_pkg::*;
#(
   parameter int HALF = 80
) (
   // Clock, reset and bench controls
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic lineOn,
   input wire logic [11:0] lineMag,
   input wire logic [11:0] bulkInit,
   input wire logic [11:0] xcap,
   // Power stage pins
   input wire logic boost_gate_drive,
   output logic zeroCross,
   output pls_sense_t sense
);
   int cnt_r;
   logic boostPrev_r;
   logic [11:0] bulk_r;
   /////////////////////////////////////////////////////////////////////////
   // Crossings stop when the line is pulled, as a real line would
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cnt_r <= 0;
         zeroCross <= 1'b0;
      end else begin
         cnt_r <= (cnt_r >= HALF - 1) ? 0 : cnt_r + 1;
         if (cnt_r == HALF - 1 && lineOn) begin
            zeroCross <= !zeroCross;
         end
      end
   end
   // One code per boost pulse: slow charge keeps the sense peak bounded
   always_ff @(posedge clk_sys) begin
      boostPrev_r <= boost_gate_drive;
      if (!reset_n) begin
         bulk_r <= bulkInit;
      end else if (boost_gate_drive && !boostPrev_r && bulk_r < 12'h181) begin
         bulk_r <= bulk_r + 12'h001;
      end
   end
   assign sense = {lineMag, bulk_r, xcap};
endmodule

/* bench/pls_sequencer_tb_top.sv */
/* Bench top: scenario tasks around the block and the power stage model.
   Assumes shortened timing parameters and a 40 MHz clock. */
`timescale 1ns/1ps
module pls_sequencer_tb_top
   import pls_pkg::*;
;
   localparam int LOSS = 320;
   localparam int STOP = 1000;
   localparam int HALF = 80;
   localparam int LSS = 20000;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic lineOn = 1'b0;
   logic psOn = 1'b0;
   logic burstMode = 1'b0;
   logic [11:0] lineMag = 12'h000;
   logic [11:0] bulkInit = 12'h000;
   logic [11:0] xcap = 12'h000;
   logic [11:0] voltLoopOut = 12'h000;
   logic [15:0] llcFb = 16'hffff;
   logic zeroCross, ac_loss_flag, startup_fet_gate, boost_gate_drive;
   logic llc_gate_a, llc_gate_b;
   logic [11:0] pfcCurrentLimit;
   logic [23:0] avg_current_demand;
   pls_sense_t sense;
   int error_cnt = 0;
   int n_compared = 0;
   /////////////////////////////////////////////////////////////////////////
   initial begin
      forever #12.5 clk_sys = !clk_sys;
   end
   pls_power_stage #(.HALF(HALF)) u_stage (
      .clk_sys(clk_sys), .reset_n(reset_n), .lineOn(lineOn),
      .lineMag(lineMag), .bulkInit(bulkInit), .xcap(xcap),
      .boost_gate_drive(boost_gate_drive), .zeroCross(zeroCross),
      .sense(sense));
   pls_sequencer #(.LOSS_CYC(LOSS), .STOP_CYC(STOP), .BURST_CYC(300),
      .LLC_SS_CYC(LSS), .PFC_SS_CYC(500), .ZC_GONE_CYC(200),
      .DITHER_CYC(1000)) u_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .sense(sense),
      .voltLoopOut(voltLoopOut), .zeroCross(zeroCross),
      .burstMode(burstMode), .bias_select_power_on(psOn),
      .llc_feedback(llcFb), .ac_loss_flag(ac_loss_flag),
      .startup_fet_gate(startup_fet_gate),
      .boost_gate_drive(boost_gate_drive), .llc_gate_a(llc_gate_a),
      .llc_gate_b(llc_gate_b), .avg_current_demand(avg_current_demand),
      .pfcCurrentLimit(pfcCurrentLimit));
   /////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Outputs as one word: 4 loss, 3 discharge, 2 boost, 1 gate A, 0 gate B
   function automatic logic [4:0] outs();
      return {ac_loss_flag, startup_fet_gate, boost_gate_drive, llc_gate_a,
         llc_gate_b};
   endfunction
   task automatic restart(input logic [11:0] mag, blk, input logic on);
      reset_n <= 1'b0;
      lineOn <= 1'b1;
      lineMag <= mag;
      bulkInit <= blk;
      psOn <= on;
      xcap <= 12'h020;
      burstMode <= 1'b0;
      llcFb <= 16'hffff;
      voltLoopOut <= 12'hfff;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
   endtask
   // Bounded wait for one output level; running out ends the run
   task automatic wait_lvl(input int k, input logic lvl, input int lim,
      output int n);
      logic [4:0] o;
      n = 0;
      o = outs();
      while (o[k] !== lvl && n < lim) begin
         @(posedge clk_sys);
         o = outs();
         n++;
      end
      if (o[k] !== lvl) begin
         check("wait on output", 32'(lvl), 32'(o[k]));
         end_of_test();
      end
   endtask
   task automatic activity(input int n, input logic [4:0] m, output int act);
      act = 0;
      repeat (n) begin
         @(posedge clk_sys);
         if ((outs() & m) !== 5'h00) act++;
      end
   endtask
   task automatic period(input int k, output int p);
      int n;
      wait_lvl(k, 1'b0, 2000, n);
      wait_lvl(k, 1'b1, 2000, n);
      wait_lvl(k, 1'b0, 2000, p);
      wait_lvl(k, 1'b1, 2000, n);
      p += n;
   endtask
   /////////////////////////////////////////////////////////////////////////
   task automatic t_no_start(input logic [11:0] mag, blk);
      int act;
      restart(mag, blk, 1'b1);
      activity(3000, 5'h07, act);
      check("start activity", 0, act);
   endtask
   task automatic t_run();
      int n, w1, w2, p;
      logic gotP, shut;
      logic [1:0] first;
      logic [2:0] seen;
      logic [4:0] o;
      logic [11:0] limAt;
      n = 0;
      w1 = 0;
      gotP = 1'b0;
      shut = 1'b0;
      first = 2'b00;
      restart(12'h0a0, 12'h0b0, 1'b1);
      // Catch the first boost pulse and the first half-bridge pulse together
      while (!(gotP && shut) && n < 4000) begin
         @(posedge clk_sys);
         o = outs();
         n++;
         if (!gotP && o[2] === 1'b1) begin
            gotP = 1'b1;
            limAt = pfcCurrentLimit;
         end
         if (first === 2'b00) first = o[1:0];
         if (first !== 2'b00 && o[1] === 1'b1 && !shut) w1++;
         if (first !== 2'b00 && o[1] !== 1'b1) shut = 1'b1;
      end
      check("soft limit", 12'h181 - 12'h0b0, limAt);
      check("first gate", 2'b10, first);
      wait_lvl(1, 1'b1, 500, n);
      wait_lvl(1, 1'b0, 500, w2);
      check("half pulse", 1, 2*w1 + 4 >= w2 && 2*w1 <= w2 + 4);
      period(1, p);
      check("sweep start", 1, p >= 'h72 && p < 'h82);
      seen = 3'b000;
      repeat (16) begin
         period(2, p);
         seen |= {p == 408, p == 400, p == 392};
      end
      check("dither set", 3'b111, seen);
      repeat (LSS) @(posedge clk_sys);
      period(1, p);
      check("sweep end", 1, p >= 'h239 && p <= 'h23d);
      voltLoopOut <= 12'h000;
      repeat (1000) @(posedge clk_sys);
      activity(1000, 5'h04, n);
      check("zero duty", 0, n);
      lineMag <= 12'h1c4;
      repeat (20) @(posedge clk_sys);
      activity(1000, 5'h07, n);
      check("halt", 0, n);
   endtask
   task automatic t_loss();
      int n, act;
      logic z;
      restart(12'h0a0, 12'h0b0, 1'b1);
      llcFb <= 16'h0100;
      repeat (LSS + 1000) @(posedge clk_sys);
      period(1, n);
      check("feedback period", 1, n >= 'hfe && n <= 'h102);
      // Drop exactly one crossing, just after one has been seen
      z = zeroCross;
      for (int i = 0; i < 200 && zeroCross === z; i++) @(posedge clk_sys);
      lineOn <= 1'b0;
      repeat (HALF + 20) @(posedge clk_sys);
      lineOn <= 1'b1;
      activity(2 * LOSS, 5'h10, act);
      check("single dropout", 0, act);
      lineMag <= 12'h050;
      wait_lvl(4, 1'b1, LOSS + 3 * HALF, n);
      check("loss delay", 1, n >= LOSS - HALF);
      activity(STOP - 100, 5'h07, act);
      check("still running", 1, act > 0);
      repeat (150) @(posedge clk_sys);
      activity(1000, 5'h07, act);
      check("stopped", 0, act);
   endtask
   task automatic t_dis(input logic [11:0] xc0, xc1, input logic brst, exp);
      int n;
      logic got;
      restart(12'h0a0, 12'h0b0, 1'b0);
      xcap <= xc0;
      burstMode <= brst;
      repeat (300) @(posedge clk_sys);
      lineOn <= 1'b0;
      got = 1'b0;
      for (n = 0; n < 700 && !got; n++) begin
         @(posedge clk_sys);
         if (n == 150) xcap <= xc1;
         got = (startup_fet_gate === 1'b1);
      end
      check("discharge", exp, got);
      if (exp) begin
         check("discharge time", 1, n >= (brst ? 420 : 120)
            && n <= (brst ? 530 : 230));
         xcap <= 12'h020;
         wait_lvl(3, 1'b0, 20, n);
      end
   endtask
   /////////////////////////////////////////////////////////////////////////
   initial begin
      @(posedge clk_sys);
      t_no_start(12'h0a0, 12'h090);
      t_no_start(12'h070, 12'h0b0);
      t_run();
      t_loss();
      t_dis(12'h030, 12'h030, 1'b0, 1'b1);
      t_dis(12'h02a, 12'h02a, 1'b0, 1'b0);
      t_dis(12'h030, 12'h030, 1'b1, 1'b1);
      t_dis(12'h030, 12'h020, 1'b1, 1'b0);
      end_of_test();
   end
   // A hang anywhere counts as a mismatch
   initial begin
      repeat (95000) @(posedge clk_sys);
      error_cnt++;
      end_of_test();
   end
endmodule
